// ### ana_advert.v
// Auto-negotiation advertisement register and identifier model/revision fields
`include "ana_map.vh"
module ana_advert #(
  parameter [5:0] MODEL_CODE = `ANA_MODEL_RST, // Arbitrary value
  parameter [3:0] REV_CODE = `ANA_REV_RST // Arbitrary value
) (
  // Clock and reset
  input wire mclk,
  input wire rst_n,
  // Management register port
  input wire [4:0] reg_addr,
  input wire reg_wr,
  input wire [15:0] reg_wdata,
  output reg [15:0] reg_rdata,
  // Strap and mode pins (asynchronous)
  input wire strap_config_select_pin,
  input wire negotiation_enable_pin,
  input wire speed_select_pin,
  input wire duplex_select_pin,
  // Negotiation engine side
  input wire local_fault,
  output reg [15:0] link_code_word,
  output reg negotiate_en,
  output reg speed_100,
  output reg full_duplex,
  output wire [3:0] status_abilities
);

  // ************************************************************
  // Pin synchronisers
  // ************************************************************
  reg [3:0] pin_s1_q;
  reg [3:0] pin_s2_q;
  reg fault_s1_q;
  reg fault_s2_q;
  // No reset here: the pins must be settled when reset lifts, otherwise
  // hardware mode is seen for two edges and overwrites the ability defaults
  always @(posedge mclk) begin
    pin_s1_q <= {strap_config_select_pin, negotiation_enable_pin,
                 speed_select_pin, duplex_select_pin};
    pin_s2_q <= pin_s1_q;
    fault_s1_q <= local_fault;
    fault_s2_q <= fault_s1_q;
  end
  wire sw_mode = pin_s2_q[3];
  wire an_pin = pin_s2_q[2];
  wire spd_pin = pin_s2_q[1];
  wire dpx_pin = pin_s2_q[0];

  // ************************************************************
  // Register storage
  // ************************************************************
  reg next_page_q;
  reg resv14_q;
  reg [2:0] resv_hi_q;
  reg [3:0] taf_q;
  reg [4:0] sel_q;
  reg fault_q;
  reg [15:0] ctrl_q;
  reg override_q;
  reg [9:0] id_q;

  wire wr_adv = reg_wr && (reg_addr == `ANA_OFS_ADVERT);
  wire wr_id = reg_wr && (reg_addr == `ANA_OFS_ID_LOW);
  wire wr_ctrl = reg_wr && (reg_addr == `ANA_OFS_CTRL);
  wire wr_ovr = reg_wr && (reg_addr == `ANA_OFS_OVERRIDE);
  wire prot_ok = override_q;

  // Hardware mode ability: one bit chosen by speed and duplex pins
  reg [3:0] hw_taf;
  always @* begin
    case ({spd_pin, dpx_pin})
      2'b11: hw_taf = 4'h8;
      2'b10: hw_taf = 4'h4;
      2'b01: hw_taf = 4'h2;
      default: hw_taf = 4'h1;
    endcase
  end

  // ************************************************************
  // Next page and remote fault
  // ************************************************************
  // Next page is plain read/write; no override needed
  always @(posedge mclk) begin
    if (!rst_n) begin
      next_page_q <= 1'b0;
    end else if (wr_adv) begin
      next_page_q <= reg_wdata[`ANA_BIT_NEXT_PAGE];
    end
  end

  // Fault follows the synchronised level; management cannot write it
  always @(posedge mclk) begin
    if (!rst_n) begin
      fault_q <= 1'b0;
    end else begin
      fault_q <= fault_s2_q;
    end
  end

  // ************************************************************
  // Override-protected fields
  // ************************************************************
  // Reserved bits are stored so override writes land, but read as zero
  always @(posedge mclk) begin
    if (!rst_n) begin
      resv14_q <= 1'b0;
      resv_hi_q <= 3'h0;
      sel_q <= `ANA_SEL_RST;
    end else if (wr_adv && prot_ok) begin
      resv14_q <= reg_wdata[`ANA_BIT_RESV14];
      resv_hi_q <= reg_wdata[12:10];
      sel_q <= reg_wdata[4:0];
    end
  end

  // Hardware mode tracks pins; software mode is protected-writable
  always @(posedge mclk) begin
    if (!rst_n) begin
      taf_q <= `ANA_TAF_RST;
    end else if (!sw_mode) begin
      taf_q <= hw_taf;
    end else if (wr_adv && prot_ok) begin
      taf_q <= reg_wdata[8:5];
    end
  end

  // Identifier fields are protected like the selector
  always @(posedge mclk) begin
    if (!rst_n) begin
      id_q <= {MODEL_CODE, REV_CODE};
    end else if (wr_id && prot_ok) begin
      id_q <= reg_wdata[9:0];
    end
  end

  // ************************************************************
  // Control and override registers
  // ************************************************************
  always @(posedge mclk) begin
    if (!rst_n) begin
      ctrl_q <= `ANA_CTRL_RST;
      override_q <= 1'b0;
    end else begin
      if (wr_ctrl) begin
        ctrl_q <= reg_wdata;
      end
      if (wr_ovr) begin
        override_q <= reg_wdata[`ANA_BIT_OVERRIDE];
      end
    end
  end

  // ************************************************************
  // Advertisement word and mode outputs
  // ************************************************************
  wire [15:0] adv_word = {next_page_q, 1'b0, fault_q, 3'b000, 1'b0,
                          taf_q, sel_q};
  // Reserved values are not sent to the partner; they are IEEE-zero

  assign status_abilities = 4'hF;

  always @(posedge mclk) begin
    if (!rst_n) begin
      link_code_word <= 16'h0000;
      negotiate_en <= 1'b0;
      speed_100 <= 1'b0;
      full_duplex <= 1'b0;
    end else begin
      link_code_word <= adv_word;
      if (!sw_mode) begin
        negotiate_en <= an_pin;
        speed_100 <= spd_pin;
        full_duplex <= dpx_pin;
      end else begin
        negotiate_en <= ctrl_q[`ANA_BIT_CTRL_AN_EN];
        speed_100 <= ctrl_q[`ANA_BIT_CTRL_SPEED];
        full_duplex <= ctrl_q[`ANA_BIT_CTRL_DUPLEX];
      end
    end
  end

  // ************************************************************
  // Read data
  // ************************************************************
  always @(posedge mclk) begin
    if (!rst_n) begin
      reg_rdata <= 16'h0000;
    end else begin
      case (reg_addr)
        `ANA_OFS_ADVERT: reg_rdata <= adv_word;
        `ANA_OFS_ID_LOW: reg_rdata <= {6'h00, id_q};
        `ANA_OFS_CTRL: reg_rdata <= ctrl_q;
        `ANA_OFS_OVERRIDE: reg_rdata <= {override_q, 15'h0000};
        default: reg_rdata <= 16'h0000;
      endcase
    end
  end
endmodule

// ### ana_advert_sva.sv
// Checker for the advertisement register block
module ana_advert_sva (
  input wire mclk, rst_n, reg_wr, local_fault,
  input wire [4:0] reg_addr,
  input wire [15:0] reg_wdata, reg_rdata, link_code_word,
  input wire strap_config_select_pin, negotiation_enable_pin,
  input wire speed_select_pin, duplex_select_pin,
  input wire negotiate_en, speed_100, full_duplex,
  input wire [3:0] status_abilities
);
  default clocking @(posedge mclk); endclocking
  default disable iff (!rst_n);
  a_abil_all: assert property (status_abilities == 4'hF)
    else $error("abilities");
  a_t4_zero: assert property (!link_code_word[9])
    else $error("t4 bit");
  a_resv_zero: assert property ($past(reg_addr) == 5'h04 |->
    reg_rdata[14] == 1'b0 && reg_rdata[12:10] == 3'h0) else $error("resv");
  a_word_mirror: assert property ($past(reg_addr) == 5'h04 |->
    reg_rdata == link_code_word) else $error("code word");
  a_fault_sent: assert property ($rose(local_fault) |->
    ##[1:5] link_code_word[13]) else $error("fault bit");
  a_next_page: assert property (reg_wr && reg_addr == 5'h04 |->
    ##2 link_code_word[15] == $past(reg_wdata[15], 2)) else $error("np");
  a_sel_hold: assert property ($past(rst_n, 3) && !$past(reg_wr, 2) |->
    $stable(link_code_word[4:0])) else $error("selector");
  // Six cycles cover pin sync plus the registered outputs
  a_hw_pins: assert property ((!strap_config_select_pin &&
    negotiation_enable_pin && speed_select_pin && !duplex_select_pin)[*6]
    |-> negotiate_en && speed_100 && !full_duplex &&
    link_code_word[8:5] == 4'h4) else $error("hw mode");
  c_ovr_wr: cover property (reg_wr && reg_addr == 5'h10);
  c_fault: cover property ($rose(link_code_word[13]));
  c_hw: cover property (!strap_config_select_pin && negotiate_en);
endmodule
bind ana_advert ana_advert_sva i_sva (.*);

// ### ana_advert_tb.sv
// Self-checking bench for the advertisement register block
module ana_advert_tb;
  timeunit 1ns;
  timeprecision 1ps;
  localparam [5:0] MODEL = 6'h2A; // Arbitrary value
  localparam [3:0] REV = 4'h5; // Arbitrary value
  logic mclk = 1'b0, rst_n = 1'b0, strap = 1'b1, neg = 1'b1;
  logic spd = 1'b1, dpx = 1'b1, fault = 1'b0, wr, an, s100, fd;
  logic [4:0] addr;
  logic [15:0] wdata, rdata, lcw;
  logic [3:0] abil;
  int errors = 0, n_checks = 0;
  always #2 mclk = ~mclk;
  ana_sta i_sta (.mclk(mclk), .reg_addr(addr), .reg_wr(wr),
    .reg_wdata(wdata), .reg_rdata(rdata));
  ana_advert #(.MODEL_CODE(MODEL), .REV_CODE(REV)) i_dut (.mclk(mclk),
    .rst_n(rst_n), .reg_addr(addr), .reg_wr(wr), .reg_wdata(wdata),
    .reg_rdata(rdata), .strap_config_select_pin(strap),
    .negotiation_enable_pin(neg), .speed_select_pin(spd),
    .duplex_select_pin(dpx), .local_fault(fault), .link_code_word(lcw),
    .negotiate_en(an), .speed_100(s100), .full_duplex(fd),
    .status_abilities(abil));
  task automatic chk(input [15:0] got, input [15:0] exp);
    n_checks++;
    if (got !== exp) begin
      errors++;
      $display("unexpected at %0t: got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic rdchk(input [4:0] a, input [15:0] exp);
    logic [15:0] v;
    i_sta.rd(a, v);
    chk(v, exp);
  endtask
  task automatic end_sim;
    $display("errors %0d checks %0d", errors, n_checks);
    if (errors == 0 && n_checks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  initial begin
    repeat (3) @(posedge mclk);
    rst_n <= 1'b1;
    rdchk(5'h04, 16'h01E1);
    rdchk(5'h03, {6'h00, MODEL, REV});
    chk({12'h000, abil}, 16'h000F);
    chk({13'h0000, an, s100, fd}, 16'h0007);
    i_sta.wr(5'h04, 16'h8000);
    rdchk(5'h04, 16'h81E1);
    i_sta.wr(5'h10, 16'h8000);
    i_sta.wr(5'h04, 16'h5C41);
    rdchk(5'h04, 16'h0041);
    @(posedge mclk) fault <= 1'b1;
    repeat (4) @(posedge mclk);
    rdchk(5'h04, 16'h2041);
    @(posedge mclk) fault <= 1'b0;
    i_sta.wr(5'h00, 16'h0000);
    repeat (2) @(posedge mclk);
    #1 chk({13'h0000, an, s100, fd}, 16'h0000);
    @(posedge mclk) strap <= 1'b0;
    dpx <= 1'b0;
    repeat (8) @(posedge mclk);
    #1 chk({13'h0000, an, s100, fd}, 16'h0006);
    i_sta.wr(5'h04, 16'h01E1);
    rdchk(5'h04, 16'h0081);
    chk(lcw, 16'h0081);
    @(posedge mclk) neg <= 1'b0;
    repeat (6) @(posedge mclk);
    #1 chk({13'h0000, an, s100, fd}, 16'h0002);
    end_sim;
  end
  // Whole sequence needs well under a microsecond
  initial begin
    #10000;
    errors++;
    end_sim;
  end
endmodule

// ### ana_map.vh
// Register offsets, field positions and reset values for the advertisement block
`ifndef ANA_MAP_VH
`define ANA_MAP_VH
`define ANA_OFS_ID_LOW 5'h03
`define ANA_OFS_ADVERT 5'h04
`define ANA_OFS_CTRL 5'h00
`define ANA_OFS_OVERRIDE 5'h10
`define ANA_BIT_NEXT_PAGE 15
`define ANA_BIT_RESV14 14
`define ANA_BIT_REMOTE_FAULT 13
`define ANA_BIT_T4 9
`define ANA_BIT_OVERRIDE 15
`define ANA_BIT_CTRL_SPEED 13
`define ANA_BIT_CTRL_AN_EN 12
`define ANA_BIT_CTRL_DUPLEX 8
`define ANA_TAF_RST 4'hF
`define ANA_SEL_RST 5'h01
`define ANA_RESV_RST 4'h0
`define ANA_MODEL_RST 6'h15
`define ANA_REV_RST 4'h3
`define ANA_CTRL_RST 16'h3100
`endif

// ### ana_sta.sv
// Station management model driving the register port
module ana_sta (
  input wire mclk,
  output logic [4:0] reg_addr = 5'h00,
  output logic reg_wr = 1'b0,
  output logic [15:0] reg_wdata = 16'h0000,
  input wire [15:0] reg_rdata
);
  timeunit 1ns;
  timeprecision 1ps;
  task automatic wr(input [4:0] a, input [15:0] d);
    @(posedge mclk);
    reg_addr <= a;
    reg_wdata <= (a == 5'h04) ? (d & 16'hA3FF) : d;
    reg_wr <= 1'b1;
    @(posedge mclk);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(input [4:0] a, output [15:0] d);
    @(posedge mclk);
    reg_addr <= a;
    repeat (2) @(posedge mclk);
    #1 d = reg_rdata;
  endtask
endmodule
